// ---- core_model.sv ----
// core model: enters the watchdog vector when its interrupt is raised
// assumes the block's clock; slow_i stretches the answer to ten cycles
`timescale 1ns/10ps
module core_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    input wire logic wd_irq_i,
    output logic wd_irq_ack_o
);
    logic [3:0] wait_cnt;

    // one acknowledge pulse per raised request, never while idle
    always_ff @(posedge clk_i) begin
        wd_irq_ack_o <= 1'b0;
        if (sys_rst_i || !wd_irq_i || wd_irq_ack_o) begin
            wait_cnt <= slow_i ? 4'h9 : 4'h1;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else begin
            wd_irq_ack_o <= 1'b1;
        end
    end
endmodule : core_model

// ---- sleep_reset_watchdog_ctrl.sv ----
// sleep control, peripheral clock gating, reset sequencing and watchdog
// assumes core strobes on clk_i; pins and fuses arrive asynchronously
// and pass a three-stage filter; the watchdog oscillator arrives as a pin
`timescale 1ns/10ps
module sleep_reset_watchdog_ctrl #(
    parameter int RESET_DELAY = srw_pkg::RESET_DELAY_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    input wire logic sleep_instr_i,
    input wire logic wdr_instr_i,
    input wire logic irq_pending_i,
    input wire logic wd_irq_ack_i,
    input wire logic ext_reset_n_i,
    input wire logic rst_pin_enable_i,
    input wire logic supply_por_i,
    input wire logic supply_below_i,
    input wire logic watchdog_lock_fuse_i,
    input wire logic wd_osc_i,
    output logic internal_reset_o,
    output logic port_reset_o,
    output logic fetch_vector_o,
    output logic cpu_halt_o,
    output logic sleeping_o,
    output logic [2:0] sleep_mode_o,
    output logic adc_clk_en_o,
    output logic timer_clk_en_o,
    output logic comp_mux_allow_o,
    output logic supply_low_irq_o,
    output logic watchdog_irq_o,
    output logic [2:0] supply_level_o
);
    srw_pkg::state_t s;
    srw_pkg::state_t n;
    logic [srw_pkg::PIN_COUNT-1:0] pins;
    logic [srw_pkg::PIN_COUNT-1:0] rise;
    logic fuse;
    logic ext_low;
    logic por;
    logic below;
    logic wd_re_eff;
    logic unlocked;
    logic wd_on;
    logic hard;
    logic wake;
    logic io_run;
    logic adc_run;
    logic [2:0] sel;
    logic [2:0] flags_keep;
    logic raw_src;
    logic port_rst;

    // ten periods; reserved codes saturate at the longest one
    function automatic logic [20:0] wd_limit(input logic [3:0] p);
        logic [3:0] idx;
        idx = (p > srw_pkg::WD_LAST_PERIOD) ? srw_pkg::WD_LAST_PERIOD : p;
        return srw_pkg::WD_BASE_TICKS << idx;
    endfunction : wd_limit

    assign pins = {watchdog_lock_fuse_i, rst_pin_enable_i, wd_osc_i,
                   supply_below_i, supply_por_i, ext_reset_n_i};

    always_comb begin
        n = s;
        rise = '0;
        fuse = 1'b0;
        ext_low = 1'b0;
        por = 1'b0;
        below = 1'b0;
        wd_re_eff = 1'b0;
        unlocked = 1'b0;
        wd_on = 1'b0;
        hard = 1'b0;
        wake = 1'b0;
        io_run = 1'b0;
        adc_run = 1'b0;
        sel = s.r.sleep_control[srw_pkg::SLEEP_SEL_LSB +: 3];
        flags_keep = '0;

        // level changes only once stages two and three agree
        n.s1 = pins;
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 | s.s3));
        rise = n.lvl & ~s.lvl;

        fuse = s.lvl[srw_pkg::PIN_LOCK];
        ext_low = s.lvl[srw_pkg::PIN_RST_EN] & ~s.lvl[srw_pkg::PIN_EXT_N];
        por = s.lvl[srw_pkg::PIN_POR];
        below = (s.r.sup_level != 3'h0) & s.lvl[srw_pkg::PIN_BELOW];
        // a pending watchdog reset flag keeps reset mode forced on
        wd_re_eff = s.r.watchdog_reset_enable | fuse
                    | s.r.rst_flags[srw_pkg::RF_WD];
        unlocked = s.unlock_cnt != 3'h0;
        n.vector = 1'b0;
        n.wd_pulse = 1'b0;
        if (unlocked) begin
            n.unlock_cnt = s.unlock_cnt - 3'h1;
        end

        if (we_i) begin
            case (addr_i)
                srw_pkg::SLEEP_CONTROL_ADDR: begin
                    n.r.sleep_control = wdata_i[3:0];
                end
                srw_pkg::CLOCK_GATE_ADDR: begin
                    n.r.peripheral_clock_gate = wdata_i[1:0];
                end
                srw_pkg::SUPPLY_CTRL_ADDR: begin
                    n.r.sup_level = wdata_i[2:0];
                    n.r.supply_low_irq_enable = wdata_i[srw_pkg::SUP_IE_BIT];
                    n.r.sup_rst = wdata_i[srw_pkg::SUP_RST_BIT];
                    // cleared by zero or level change
                    if (!wdata_i[srw_pkg::SUP_FLAG_BIT]
                        || wdata_i[2:0] != s.r.sup_level) begin
                        n.r.supply_low_flag = 1'b0;
                    end
                end
                srw_pkg::RESET_FLAGS_ADDR: begin
                    n.r.rst_flags = s.r.rst_flags & wdata_i[2:0];
                end
                srw_pkg::WD_CTRL_ADDR: begin
                    if (wdata_i[srw_pkg::WD_FLAG_BIT]) begin
                        n.r.wd_flag = 1'b0;
                    end
                    n.r.wd_ie = wdata_i[srw_pkg::WD_IE_BIT];
                    if (!fuse && (wdata_i[srw_pkg::WD_RE_BIT] || unlocked)) begin
                        n.r.watchdog_reset_enable = wdata_i[srw_pkg::WD_RE_BIT];
                    end
                    if (!fuse || unlocked) begin
                        n.r.watchdog_period = {wdata_i[srw_pkg::WD_P3_BIT],
                                               wdata_i[2:0]};
                    end
                    n.unlock_cnt = 3'h0;
                end
                srw_pkg::UNLOCK_ADDR: begin
                    if (wdata_i == srw_pkg::UNLOCK_SIGNATURE) begin
                        n.unlock_cnt = srw_pkg::UNLOCK_WINDOW_CYCLES;
                    end
                end
                default: begin
                end
            endcase
        end

        // vector entry: flag cleared, reset-mode combo drops the enable
        if (wd_irq_ack_i) begin
            n.r.wd_flag = 1'b0;
            if (wd_re_eff) begin
                n.r.wd_ie = 1'b0;
            end
        end

        // kick or disable clears the count
        wd_on = wd_re_eff | s.r.wd_ie;
        if (!wd_on || wdr_instr_i) begin
            n.wd_cnt = '0;
        // one step per oscillator rising edge
        end else if (rise[srw_pkg::PIN_OSC]) begin
            if (s.wd_cnt + 21'h1 == wd_limit(s.r.watchdog_period)) begin
                n.wd_cnt = '0;
                // interrupt first, reset if still unserved; with the lock fuse or the enable clear, reset at once
                if (fuse || (wd_re_eff && (!s.r.wd_ie || s.r.wd_flag))) begin
                    n.wd_pulse = 1'b1;
                end else begin
                    n.r.wd_flag = 1'b1;
                end
            end else begin
                n.wd_cnt = s.wd_cnt + 21'h1;
            end
        end

        // auto clear on recovery, set wins over any clear
        if (!below) begin
            n.r.supply_low_flag = 1'b0;
        end
        // rise is seen one cycle before below, so test the level alone
        if ((s.r.sup_level != 3'h0) && rise[srw_pkg::PIN_BELOW]) begin
            n.r.supply_low_flag = 1'b1;
        end

        // any source pulls reset in the next cycle
        // supply monitor reset mode joins the sources
        // pin masked during the power-on count
        hard = por | (below & s.r.sup_rst) | s.wd_pulse
               | (ext_low & ~s.por_phase);
        if (por) begin
            n.por_phase = 1'b1;
            n.por_seen = 1'b1;
        end
        // power-on flag once supply is back
        if (s.por_seen && !por) begin
            n.r.rst_flags[srw_pkg::RF_POWER_ON] = 1'b1;
            n.por_seen = 1'b0;
        end
        if (ext_low && !s.por_phase && s.rst_st == srw_pkg::RST_RUN) begin
            n.r.rst_flags[srw_pkg::RF_EXT] = 1'b1;
        end
        if (s.wd_pulse) begin
            n.r.rst_flags[srw_pkg::RF_WD] = 1'b1;
        end

        case (s.rst_st)
            srw_pkg::RST_HOLD: begin
                if (!hard) begin
                    n.rst_st = srw_pkg::RST_DELAY;
                    n.rst_cnt = '0;
                end
            end
            srw_pkg::RST_DELAY: begin
                if (hard) begin
                    n.rst_st = srw_pkg::RST_HOLD;
                end else if (s.rst_cnt == 20'(RESET_DELAY - 1)) begin
                    n.por_phase = 1'b0;
                    // pin still low extends the reset
                    if (s.por_phase && ext_low) begin
                        n.rst_st = srw_pkg::RST_HOLD;
                    end else begin
                        n.rst_st = srw_pkg::RST_RUN;
                        n.vector = 1'b1;
                    end
                end else begin
                    n.rst_cnt = s.rst_cnt + 20'h1;
                end
            end
            srw_pkg::RST_RUN: begin
                if (hard) begin
                    n.rst_st = srw_pkg::RST_HOLD;
                end
            end
            default: begin
                n.rst_st = srw_pkg::RST_HOLD;
            end
        endcase

        // watchdog interrupt is a wake source
        wake = irq_pending_i | (s.r.wd_flag & s.r.wd_ie);
        case (s.pwr_st)
            srw_pkg::PWR_RUN: begin
                if (sleep_instr_i && s.r.sleep_control[srw_pkg::SLEEP_ARM_BIT]
                    && (sel == srw_pkg::SEL_IDLE || sel == srw_pkg::SEL_ADC_NR
                        || sel == srw_pkg::SEL_POWER_DOWN
                        || sel == srw_pkg::SEL_STANDBY)) begin
                    n.pwr_st = srw_pkg::PWR_SLEEP;
                    n.mode = sel;
                end
            end
            srw_pkg::PWR_SLEEP: begin
                if (wake) begin
                    n.pwr_st = srw_pkg::PWR_WAKE;
                    n.wake_cnt = srw_pkg::WAKE_HALT_CYCLES - 8'h01;
                    if (s.mode == srw_pkg::SEL_POWER_DOWN) begin
                        n.wake_cnt = srw_pkg::OSC_STARTUP_CYCLES
                                     + srw_pkg::WAKE_HALT_CYCLES - 8'h01;
                    end
                end
            end
            srw_pkg::PWR_WAKE: begin
                if (s.wake_cnt == 8'h00) begin
                    n.pwr_st = srw_pkg::PWR_RUN;
                end else begin
                    n.wake_cnt = s.wake_cnt - 8'h01;
                end
            end
            default: begin
                n.pwr_st = srw_pkg::PWR_RUN;
            end
        endcase

        // registers and watchdog back to initial values
        // flags survive so software can see what caused the reset
        if (n.rst_st != srw_pkg::RST_RUN) begin
            flags_keep = n.r.rst_flags;
            n.r = srw_pkg::REGS_RESET;
            n.r.rst_flags = flags_keep;
            n.wd_cnt = '0;
            n.unlock_cnt = 3'h0;
            n.pwr_st = srw_pkg::PWR_RUN;
            n.mode = 3'h0;
            n.wake_cnt = 8'h00;
        end

        n.int_rst = n.rst_st != srw_pkg::RST_RUN;
        n.halt = n.int_rst | (n.pwr_st != srw_pkg::PWR_RUN);
        n.sleeping = n.pwr_st == srw_pkg::PWR_SLEEP;
        io_run = n.pwr_st != srw_pkg::PWR_SLEEP || n.mode == srw_pkg::SEL_IDLE;
        adc_run = io_run || n.mode == srw_pkg::SEL_ADC_NR;
        // gated timer clock holds its state
        n.tim_en = ~n.r.peripheral_clock_gate[srw_pkg::TIMER_GATE_BIT]
                   & io_run;
        // adc clock and comparator mux access
        n.adc_en = ~n.r.peripheral_clock_gate[srw_pkg::ADC_GATE_BIT] & adc_run;
        n.comp_mux = ~n.r.peripheral_clock_gate[srw_pkg::ADC_GATE_BIT];
        n.sup_irq = n.r.supply_low_flag & n.r.supply_low_irq_enable;
        n.wd_irq = n.r.wd_flag & n.r.wd_ie;

        // read data valid the cycle after the strobe only
        n.rdata = 8'h00;
        if (re_i) begin
            case (addr_i)
                srw_pkg::SLEEP_CONTROL_ADDR: begin
                    n.rdata = {4'h0, s.r.sleep_control};
                end
                srw_pkg::CLOCK_GATE_ADDR: begin
                    n.rdata = {6'h00, s.r.peripheral_clock_gate};
                end
                srw_pkg::SUPPLY_CTRL_ADDR: begin
                    n.rdata = {2'h0, s.r.supply_low_flag, s.r.sup_rst,
                               s.r.supply_low_irq_enable, s.r.sup_level};
                end
                srw_pkg::RESET_FLAGS_ADDR: begin
                    n.rdata = {5'h00, s.r.rst_flags};
                end
                srw_pkg::WD_CTRL_ADDR: begin
                    n.rdata = {s.r.wd_flag, s.r.wd_ie,
                               s.r.watchdog_period[3], 1'b0, wd_re_eff,
                               s.r.watchdog_period[2:0]};
                end
                default: begin
                    n.rdata = 8'h00;
                end
            endcase
        end

        if (sys_rst_i) begin
            n = '0;
            n.int_rst = 1'b1;
            n.halt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= n;
    end

    // pins reset without a clock; raw sources may glitch the
    // pins briefly, which only costs a spurious tristate, never a drive
    assign raw_src = supply_por_i | (rst_pin_enable_i & ~ext_reset_n_i);
    always_ff @(posedge clk_i or posedge raw_src) begin
        if (raw_src) begin
            port_rst <= 1'b1;
        end else begin
            port_rst <= s.int_rst | sys_rst_i;
        end
    end

    assign rdata_o = s.rdata;
    assign internal_reset_o = s.int_rst;
    assign port_reset_o = port_rst;
    assign fetch_vector_o = s.vector;
    assign cpu_halt_o = s.halt;
    assign sleeping_o = s.sleeping;
    assign sleep_mode_o = s.mode;
    assign adc_clk_en_o = s.adc_en;
    assign timer_clk_en_o = s.tim_en;
    assign comp_mux_allow_o = s.comp_mux;
    assign supply_low_irq_o = s.sup_irq;
    assign watchdog_irq_o = s.wd_irq;
    assign supply_level_o = s.r.sup_level;
endmodule : sleep_reset_watchdog_ctrl

// ---- srw_assertions.sv ----
// assertion checker for the sleep/reset/watchdog block
// assumes bind onto the block with the same reset delay parameter
`timescale 1ns/10ps
module srw_checker #(
    parameter int RESET_DELAY = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [7:0] rdata_o,
    input wire logic sleep_instr_i,
    input wire logic supply_por_i,
    input wire logic internal_reset_o,
    input wire logic sleeping_o,
    input wire logic [2:0] sleep_mode_o,
    input wire logic adc_clk_en_o,
    input wire logic comp_mux_allow_o
);
    logic [15:0] rst_len;

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // length of the current internal reset, saturating
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !internal_reset_o) begin
            rst_len <= 16'h0000;
        end else if (rst_len != 16'hffff) begin
            rst_len <= rst_len + 16'h0001;
        end
    end

    rdata_idle_a: assert property (
        !$past(re_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    sleep_upper_a: assert property (
        $past(re_i && addr_i == srw_pkg::SLEEP_CONTROL_ADDR)
        |-> rdata_o[7:4] == 4'h0) else $error("upper sleep bits set");
    adc_gate_a: assert property (
        we_i && addr_i == srw_pkg::CLOCK_GATE_ADDR && !internal_reset_o
        |=> adc_clk_en_o == !$past(wdata_i[srw_pkg::ADC_GATE_BIT]))
        else $error("adc clock not following gate bit");
    comp_mux_a: assert property (
        !sleeping_o |-> comp_mux_allow_o == adc_clk_en_o)
        else $error("comparator mux allowed while adc gated");
    sleep_cause_a: assert property (
        $rose(sleeping_o) |-> $past(sleep_instr_i))
        else $error("sleep without sleep instruction");
    sleep_code_a: assert property (
        sleeping_o |-> sleep_mode_o inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("sleeping in a reserved mode");
    reset_len_a: assert property (
        $fell(internal_reset_o) |-> rst_len >= 16'(RESET_DELAY))
        else $error("internal reset too short");
    por_reset_a: assert property (
        $rose(supply_por_i) |-> ##[0:5] internal_reset_o)
        else $error("low supply gave no reset");
endmodule : srw_checker

bind sleep_reset_watchdog_ctrl srw_checker
    #(.RESET_DELAY(RESET_DELAY)) chk_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .sleep_instr_i(sleep_instr_i), .supply_por_i(supply_por_i),
    .internal_reset_o(internal_reset_o), .sleeping_o(sleeping_o),
    .sleep_mode_o(sleep_mode_o), .adc_clk_en_o(adc_clk_en_o),
    .comp_mux_allow_o(comp_mux_allow_o)
);

// ---- srw_pkg.sv ----
// constants, register map and state types for the sleep/reset/watchdog block
// assumes a single 20 MHz clock and an 8-bit register port with 6-bit address
package srw_pkg;
    // register offsets in the i/o space
    localparam logic [5:0] WD_CTRL_ADDR = 6'h31;
    localparam logic [5:0] SUPPLY_CTRL_ADDR = 6'h34;
    localparam logic [5:0] CLOCK_GATE_ADDR = 6'h35;
    localparam logic [5:0] SLEEP_CONTROL_ADDR = 6'h3a;
    localparam logic [5:0] RESET_FLAGS_ADDR = 6'h3b;
    localparam logic [5:0] UNLOCK_ADDR = 6'h3c;
    localparam logic [7:0] UNLOCK_SIGNATURE = 8'hd8;

    // field positions
    localparam int SLEEP_ARM_BIT = 0;
    localparam int SLEEP_SEL_LSB = 1;
    localparam int TIMER_GATE_BIT = 0;
    localparam int ADC_GATE_BIT = 1;
    localparam int SUP_IE_BIT = 3;
    localparam int SUP_RST_BIT = 4;
    localparam int SUP_FLAG_BIT = 5;
    localparam int WD_FLAG_BIT = 7;
    localparam int WD_IE_BIT = 6;
    localparam int WD_P3_BIT = 5;
    localparam int WD_RE_BIT = 3;
    localparam int RF_POWER_ON = 0;
    localparam int RF_EXT = 1;
    localparam int RF_WD = 2;

    // sleep select encodings
    localparam logic [2:0] SEL_IDLE = 3'h0;
    localparam logic [2:0] SEL_ADC_NR = 3'h1;
    localparam logic [2:0] SEL_POWER_DOWN = 3'h2;
    localparam logic [2:0] SEL_STANDBY = 3'h4;

    // pin vector positions
    localparam int PIN_EXT_N = 0;
    localparam int PIN_POR = 1;
    localparam int PIN_BELOW = 2;
    localparam int PIN_OSC = 3;
    localparam int PIN_RST_EN = 4;
    localparam int PIN_LOCK = 5;
    localparam int PIN_COUNT = 6;

    // timing
    localparam int CLK_MHZ = 20;
    localparam int RESET_TIMEOUT_US = 64;
    localparam int RESET_DELAY_CYCLES = RESET_TIMEOUT_US * CLK_MHZ;
    localparam int OSC_STARTUP_US = 6;
    localparam logic [7:0] OSC_STARTUP_CYCLES = 8'(OSC_STARTUP_US * CLK_MHZ);
    localparam logic [7:0] WAKE_HALT_CYCLES = 8'h04;
    localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
    localparam logic [20:0] WD_BASE_TICKS = 21'h000800;
    localparam logic [3:0] WD_LAST_PERIOD = 4'h9;

    typedef enum logic [1:0] {RST_HOLD, RST_DELAY, RST_RUN} rst_state_t;
    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} pwr_state_t;

    typedef struct packed {
        logic [3:0] sleep_control;
        logic [1:0] peripheral_clock_gate;
        logic [2:0] sup_level;
        logic supply_low_irq_enable;
        logic sup_rst;
        logic supply_low_flag;
        logic wd_flag;
        logic wd_ie;
        logic watchdog_reset_enable;
        logic [3:0] watchdog_period;
        logic [2:0] rst_flags;
    } regs_t;

    localparam regs_t REGS_RESET = '0;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] lvl;
        rst_state_t rst_st;
        logic [19:0] rst_cnt;
        logic por_phase;
        logic por_seen;
        pwr_state_t pwr_st;
        logic [2:0] mode;
        logic [7:0] wake_cnt;
        logic [20:0] wd_cnt;
        logic wd_pulse;
        logic [2:0] unlock_cnt;
        regs_t r;
        logic [7:0] rdata;
        logic int_rst;
        logic vector;
        logic halt;
        logic sleeping;
        logic adc_en;
        logic tim_en;
        logic comp_mux;
        logic sup_irq;
        logic wd_irq;
    } state_t;
endpackage : srw_pkg

// ---- testbench.sv ----
// self-checking bench for the sleep/reset/watchdog block
// assumes the bound checker and core_model; reset delay shortened to 8
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00;
    logic we_i = 1'b0, re_i = 1'b0, sleep_instr_i = 1'b0, re_d = 1'b0;
    logic irq_pending_i = 1'b0, ext_reset_n_i = 1'b1, supply_por_i = 1'b0;
    logic supply_below_i = 1'b0, wd_osc_i = 1'b0, osc_run = 1'b0;
    logic slow = 1'b1;
    logic wdr_instr_i = 1'b0;
    logic [7:0] rdata_o;
    logic [2:0] sleep_mode_o, supply_level_o;
    logic internal_reset_o, port_reset_o, fetch_vector_o, cpu_halt_o;
    logic sleeping_o, adc_clk_en_o, timer_clk_en_o, comp_mux_allow_o;
    logic supply_low_irq_o, watchdog_irq_o, wd_ack;
    logic [15:0] rd_q[$];
    int bad_count = 0, checks_done = 0;

    sleep_reset_watchdog_ctrl #(.RESET_DELAY(8)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .sleep_instr_i(sleep_instr_i), .wdr_instr_i(wdr_instr_i),
        .irq_pending_i(irq_pending_i), .wd_irq_ack_i(wd_ack),
        .ext_reset_n_i(ext_reset_n_i), .rst_pin_enable_i(1'b1),
        .supply_por_i(supply_por_i), .supply_below_i(supply_below_i),
        .watchdog_lock_fuse_i(1'b0), .wd_osc_i(wd_osc_i),
        .internal_reset_o(internal_reset_o), .port_reset_o(port_reset_o),
        .fetch_vector_o(fetch_vector_o), .cpu_halt_o(cpu_halt_o),
        .sleeping_o(sleeping_o), .sleep_mode_o(sleep_mode_o),
        .adc_clk_en_o(adc_clk_en_o), .timer_clk_en_o(timer_clk_en_o),
        .comp_mux_allow_o(comp_mux_allow_o),
        .supply_low_irq_o(supply_low_irq_o),
        .watchdog_irq_o(watchdog_irq_o), .supply_level_o(supply_level_o)
    );
    core_model core_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .wd_irq_i(watchdog_irq_o), .wd_irq_ack_o(wd_ack));

    initial forever #25 clk_i = ~clk_i;
    // fast stand-in oscillator keeps watchdog runs short
    initial forever begin
        repeat (4) @(posedge clk_i);
        wd_osc_i <= osc_run & ~wd_osc_i;
    end

    task automatic fail(input string msg);
        bad_count++;
        $display("CHECK FAILED %0t %s", $time, msg);
    endtask : fail
    task automatic chk(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp) fail(msg);
    endtask : chk
    task automatic chk_rd(input logic [15:0] note);
        checks_done++;
        if ((rdata_o & note[15:8]) !== note[7:0]) fail("read data");
    endtask : chk_rd
    // read notes: mask in the high byte, expected value in the low byte
    always @(posedge clk_i) re_d <= re_i;
    always @(negedge clk_i) begin
        if (re_d) chk_rd(rd_q.pop_front());
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        rd_q.push_back({m, e});
        @(posedge clk_i);
        re_i <= 1'b0;
    endtask : rd
    function automatic logic sig(input int k);
        case (k)
            0: return internal_reset_o;
            1: return cpu_halt_o;
            2: return watchdog_irq_o;
            default: return supply_low_irq_o;
        endcase
    endfunction : sig
    task automatic wait_on(input int k, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (sig(k) !== v && n < lim);
        chk(sig(k), v, "level not reached in time");
    endtask : wait_on
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (60000) @(posedge clk_i);
        fail("run too long");
        end_of_test();
    end

    initial begin
        logic [7:0] d;
        logic ok;
        void'($urandom(62640));
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_on(0, 1'b0, 100);
        chk(adc_clk_en_o, 1'b1, "adc clock after reset");
        rd(srw_pkg::SLEEP_CONTROL_ADDR, 8'hff, 8'h00);
        d = 8'($urandom);
        wr(srw_pkg::SLEEP_CONTROL_ADDR, d);
        rd(srw_pkg::SLEEP_CONTROL_ADDR, 8'hff, {4'h0, d[3:0]});
        rd(6'h00, 8'hff, 8'h00);
        wr(srw_pkg::CLOCK_GATE_ADDR, 8'h03); // adc idle first
        @(negedge clk_i);
        chk(comp_mux_allow_o, 1'b0, "comparator mux");
        chk(timer_clk_en_o, 1'b0, "timer gated");
        rd(srw_pkg::CLOCK_GATE_ADDR, 8'hff, 8'h03);
        wr(srw_pkg::CLOCK_GATE_ADDR, 8'h00);
        @(negedge clk_i);
        chk(timer_clk_en_o, 1'b1, "timer resumed");
        for (int k = 0; k < 16; k++) begin
            ok = k[0] && (k[3:1] inside {3'h0, 3'h1, 3'h2, 3'h4});
            wr(srw_pkg::SLEEP_CONTROL_ADDR, 8'(k));
            @(posedge clk_i);
            sleep_instr_i <= 1'b1;
            @(posedge clk_i);
            sleep_instr_i <= 1'b0;
            @(negedge clk_i);
            chk(sleeping_o, ok, "sleep entry");
            if (ok) begin
                chk(sleep_mode_o === k[3:1], 1'b1, "mode");
                @(posedge clk_i);
                irq_pending_i <= 1'b1;
                repeat (5) @(negedge clk_i);
                chk(cpu_halt_o, 1'b1, "halt held");
                wait_on(1, 1'b0, (k[3:1] == srw_pkg::SEL_POWER_DOWN)
                        ? 1 + srw_pkg::OSC_STARTUP_CYCLES : 1);
                chk(sleeping_o, 1'b0, "woken");
                @(posedge clk_i);
                irq_pending_i <= 1'b0;
            end
        end
        wr(srw_pkg::SLEEP_CONTROL_ADDR, 8'h05);
        ext_reset_n_i <= 1'b0;
        wait_on(0, 1'b1, 10);
        chk(port_reset_o, 1'b1, "port reset");
        @(posedge clk_i);
        ext_reset_n_i <= 1'b1;
        wait_on(0, 1'b0, 40);
        rd(srw_pkg::SLEEP_CONTROL_ADDR, 8'hff, 8'h00);
        rd(srw_pkg::RESET_FLAGS_ADDR, 8'h02, 8'h02);
        supply_por_i <= 1'b1;
        wait_on(0, 1'b1, 10);
        @(posedge clk_i);
        supply_por_i <= 1'b0;
        wait_on(0, 1'b0, 40);
        rd(srw_pkg::RESET_FLAGS_ADDR, 8'h01, 8'h01);
        wr(srw_pkg::SUPPLY_CTRL_ADDR, 8'h09);
        supply_below_i <= 1'b1;
        wait_on(3, 1'b1, 10);
        rd(srw_pkg::SUPPLY_CTRL_ADDR, 8'h27, 8'h21);
        wr(srw_pkg::SUPPLY_CTRL_ADDR, 8'h09);
        wait_on(3, 1'b0, 4);
        @(posedge clk_i);
        supply_below_i <= 1'b0;
        wr(srw_pkg::WD_CTRL_ADDR, 8'h40);
        osc_run <= 1'b1;
        slow <= 1'($urandom);
        // unkicked, the period would run out before the check
        repeat (10000) @(posedge clk_i);
        wdr_instr_i <= 1'b1;
        @(posedge clk_i);
        wdr_instr_i <= 1'b0;
        repeat (8000) @(negedge clk_i);
        chk(watchdog_irq_o, 1'b0, "kick ignored");
        wait_on(2, 1'b1, 20000);
        wait_on(2, 1'b0, 20);
        wr(srw_pkg::WD_CTRL_ADDR, 8'h08);
        wr(srw_pkg::WD_CTRL_ADDR, 8'h00);
        rd(srw_pkg::WD_CTRL_ADDR, 8'h08, 8'h08);
        wr(srw_pkg::UNLOCK_ADDR, srw_pkg::UNLOCK_SIGNATURE);
        wr(srw_pkg::WD_CTRL_ADDR, 8'h00);
        rd(srw_pkg::WD_CTRL_ADDR, 8'h08, 8'h00);
        wr(srw_pkg::WD_CTRL_ADDR, 8'h08);
        wait_on(0, 1'b1, 20000);
        wait_on(0, 1'b0, 40);
        rd(srw_pkg::RESET_FLAGS_ADDR, 8'h04, 8'h04);
        osc_run <= 1'b0;
        repeat (3) @(posedge clk_i);
        end_of_test();
    end
endmodule : testbench
